// *** hw/uhcsr_pkg.sv ***
// constants, field layouts and carrier types of the host controller control/status bank
package uhcsr_pkg;

  // byte offsets of the bank's registers
  localparam logic [7:0] UHCSR_OFS_MODE   = 8'h04;
  localparam logic [7:0] UHCSR_OFS_CMD    = 8'h08;
  localparam logic [7:0] UHCSR_OFS_FLAGS  = 8'h0c;
  localparam logic [7:0] UHCSR_OFS_ENSET  = 8'h10;
  localparam logic [7:0] UHCSR_OFS_ENCLR  = 8'h14;

  // operating_mode field positions
  localparam int UHCSR_MODE_W       = 11;
  localparam int UHCSR_POS_RATIO    = 0;
  localparam int UHCSR_POS_PERIODIC = 2;
  localparam int UHCSR_POS_ISO      = 3;
  localparam int UHCSR_POS_CONTROL  = 4;
  localparam int UHCSR_POS_BULK     = 5;
  localparam int UHCSR_POS_STATE    = 6;
  localparam int UHCSR_POS_ROUTING  = 8;
  localparam int UHCSR_POS_WAKE_ATT = 9;
  localparam int UHCSR_POS_WAKE_EN  = 10;

  // functional_state encodings
  localparam logic [1:0] UHCSR_STATE_BUS_RESET  = 2'h0;
  localparam logic [1:0] UHCSR_STATE_BUS_RESUME = 2'h1;
  localparam logic [1:0] UHCSR_STATE_RUNNING    = 2'h2;
  localparam logic [1:0] UHCSR_STATE_SUSPENDED  = 2'h3;

  // command_and_status field positions
  localparam int UHCSR_CMD_W       = 4;
  localparam int UHCSR_POS_CTRL_RST = 0;
  localparam int UHCSR_POS_CTRL_FILLED = 1;
  localparam int UHCSR_POS_BULK_FILLED = 2;
  localparam int UHCSR_POS_OWN_REQ  = 3;
  localparam int UHCSR_POS_SOC      = 16;

  // event bits; index 7 of the internal vector is the ownership change event
  localparam int UHCSR_EV_W      = 8;
  localparam int UHCSR_EV_LOW_W  = 7;
  localparam int UHCSR_POS_EV_OWN = 31;
  localparam int UHCSR_POS_EN_OWN = 30;
  localparam int UHCSR_POS_GATE  = 31;

  // reset values
  localparam logic [UHCSR_MODE_W-1:0] UHCSR_MODE_RST = 11'h001;
  localparam logic [UHCSR_CMD_W-1:0]  UHCSR_CMD_RST  = 4'h0;
  localparam logic [1:0]              UHCSR_SOC_RST  = 2'h0;
  localparam logic [UHCSR_EV_W-1:0]   UHCSR_EV_RST   = 8'h00;

  // mode fields only the driver may change, and the implemented enable bits
  localparam logic [UHCSR_MODE_W-1:0] UHCSR_MODE_DRV_ONLY = 11'h53f;
  localparam logic [31:0]             UHCSR_EN_MAP        = 32'hc000007f;

  // operating_mode laid out so that bit 0 of the struct is register bit 0
  typedef struct packed {
    logic       remote_wakeup_allowed;
    logic       remote_wakeup_attached;
    logic       interrupt_routing;
    logic [1:0] functional_state;
    logic       bulk_list_on;
    logic       control_list_on;
    logic       isochronous_on;
    logic       periodic_list_on;
    logic [1:0] list_service_ratio;
  } uhcsr_mode_s;

  // updates driven by the list-processing engine
  typedef struct packed {
    logic       state_wr;
    logic [1:0] state_val;
    logic       wake_att_wr;
    logic       wake_att_val;
    logic [3:0] cmd_clr;
    logic       soc_wr;
    logic [1:0] soc_val;
  } uhcsr_hc_upd_s;

endpackage

// *** hw/uhcsr_regs.sv ***
// control, command/status and interrupt registers of the usb host controller
`timescale 1ns/100ps

module uhcsr_regs
  import uhcsr_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    ce,
  input  wire logic [7:0]              reg_addr,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  input  wire logic [31:0]             reg_wdata,
  output logic      [31:0]             reg_rdata,
  output logic                         reg_rvalid,
  input  wire uhcsr_hc_upd_s           hc_upd,
  input  wire logic [UHCSR_EV_W-1:0]   hc_event,
  output uhcsr_mode_s                  mode,
  output logic      [UHCSR_CMD_W-1:0]  cmd,
  output logic      [1:0]              overrun_count,
  output logic                         irq
);

  uhcsr_mode_s               mode_q;
  logic [UHCSR_CMD_W-1:0]    cmd_q;
  logic [1:0]                soc_q;
  logic [UHCSR_EV_W-1:0]     flags_q;
  logic [UHCSR_EV_W-1:0]     en_q;
  logic                      gate_q;
  logic                      irq_q;
  logic [31:0]               rdata_q;
  logic                      rvalid_q;
  logic                      wr_mode;
  logic                      wr_cmd;
  logic                      wr_flags;
  logic                      wr_enset;
  logic                      wr_enclr;
  logic [UHCSR_EV_W-1:0]     wev;
  logic [31:0]               mode_word;
  logic [31:0]               cmd_word;
  logic [31:0]               flags_word;
  logic [31:0]               en_word;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // address decode; every strobe already carries the clock enable
  assign wr_mode  = ce && reg_wr && (reg_addr == UHCSR_OFS_MODE);
  assign wr_cmd   = ce && reg_wr && (reg_addr == UHCSR_OFS_CMD);
  assign wr_flags = ce && reg_wr && (reg_addr == UHCSR_OFS_FLAGS);
  assign wr_enset = ce && reg_wr && (reg_addr == UHCSR_OFS_ENSET);
  assign wr_enclr = ce && reg_wr && (reg_addr == UHCSR_OFS_ENCLR);

  // write data folded onto the internal event vector, ownership change at 7
  assign wev = {reg_wdata[UHCSR_POS_EV_OWN], reg_wdata[UHCSR_EV_LOW_W-1:0]};

  ////////////////////////////////////////////////////////////////////////////
  // read views; bits not listed read as zero
  assign mode_word  = {21'h000000, mode_q};
  assign cmd_word   = {14'h0000, soc_q, 12'h000, cmd_q};
  assign flags_word = {flags_q[7], 24'h000000, flags_q[6:0]};
  assign en_word    = {gate_q, en_q[7], 23'h000000, en_q[6:0]};

  ////////////////////////////////////////////////////////////////////////////
  // operating mode: the engine may only touch state and wakeup-attached,
  // and its update wins a same-cycle driver write to those two fields
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      mode_q <= UHCSR_MODE_RST;
    end
    else if (ce)
    begin
      if (wr_mode)
      begin
        mode_q <= uhcsr_mode_s'(reg_wdata[UHCSR_MODE_W-1:0]);
      end
      if (hc_upd.state_wr)
      begin
        mode_q.functional_state <= hc_upd.state_val;
      end
      if (hc_upd.wake_att_wr)
      begin
        mode_q.remote_wakeup_attached <= hc_upd.wake_att_val;
      end
    end
  end

  AST_MODE_HC_LIMITED: assert property (
    ce && !wr_mode |=> (mode_q & UHCSR_MODE_DRV_ONLY) == ($past(mode_q) & UHCSR_MODE_DRV_ONLY))
    else $error("engine changed a driver-only mode field");
  AST_MODE_STATE_BOTH: assert property (
    ce && wr_mode && !hc_upd.state_wr
      |=> mode_q.functional_state == $past(reg_wdata[UHCSR_POS_STATE+1:UHCSR_POS_STATE]))
    else $error("driver write of functional state lost");

  ////////////////////////////////////////////////////////////////////////////
  // command bits: driver ones set, engine clears; a set beats a clear
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cmd_q <= UHCSR_CMD_RST;
    end
    else if (ce)
    begin
      cmd_q <= (cmd_q & ~hc_upd.cmd_clr)
               | (wr_cmd ? reg_wdata[UHCSR_CMD_W-1:0] : 4'h0);
    end
  end

  // overrun count belongs to the engine; driver writes never reach it
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      soc_q <= UHCSR_SOC_RST;
    end
    else if (ce && hc_upd.soc_wr)
    begin
      soc_q <= hc_upd.soc_val;
    end
  end

  AST_CMD_SET: assert property (
    wr_cmd && reg_wdata[UHCSR_POS_OWN_REQ] |=> cmd_q[UHCSR_POS_OWN_REQ])
    else $error("command write of one did not set the bit");
  AST_CMD_KEEP: assert property (
    ce && (hc_upd.cmd_clr == 4'h0) |=> (cmd_q & $past(cmd_q)) == $past(cmd_q))
    else $error("pending command lost without an engine clear");
  AST_CMD_CLR: assert property (
    ce && !wr_cmd && hc_upd.cmd_clr[UHCSR_POS_CTRL_FILLED] |=> !cmd_q[UHCSR_POS_CTRL_FILLED])
    else $error("engine clear of a command bit ignored");
  AST_SOC_RO: assert property (
    ce && wr_cmd && !hc_upd.soc_wr |=> $stable(soc_q))
    else $error("driver write changed the overrun count");

  // every command bit written as one is pending afterwards, whatever the engine clears
  AST_CMD_SET_ALL: assert property (
    wr_cmd |=> (~cmd_q & $past(reg_wdata[UHCSR_CMD_W-1:0])) == 4'h0)
    else $error("command write of ones left a bit clear");
  AST_SOC_ENGINE: assert property (
    ce && hc_upd.soc_wr |=> overrun_count == $past(hc_upd.soc_val))
    else $error("engine update of the overrun count lost");

  ////////////////////////////////////////////////////////////////////////////
  // event flags, one per bit: an event in the same cycle as a clearing
  // write keeps the flag set so it is never lost
  for (genvar i = 0; i < UHCSR_EV_W; i++)
  begin : g_flag
    always_ff @(posedge mclk or posedge rst)
    begin
      if (rst)
      begin
        flags_q[i] <= UHCSR_EV_RST[i];
      end
      else if (ce)
      begin
        if (hc_event[i])
        begin
          flags_q[i] <= 1'b1;
        end
        else if (wr_flags && wev[i])
        begin
          flags_q[i] <= 1'b0;
        end
      end
    end
  end

  AST_FLAG_SET: assert property (
    ce && hc_event[UHCSR_EV_W-1] |=> flags_q[UHCSR_EV_W-1] && flags_word[UHCSR_POS_EV_OWN])
    else $error("ownership change event not recorded");
  AST_FLAG_W1C: assert property (
    wr_flags && reg_wdata[0] && !hc_event[0] |=> !flags_word[0])
    else $error("write of one did not clear the flag");

  // a flag only ever drops through a clearing write
  AST_FLAG_HOLD: assert property (
    ce && !wr_flags |=> (~flags_q & $past(flags_q)) == 8'h00)
    else $error("event flag dropped without a clearing write");

  ////////////////////////////////////////////////////////////////////////////
  // enables: the set register writes ones in, the disable register takes
  // them out; a one on both in one cycle cannot happen as they share a bus
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      en_q   <= UHCSR_EV_RST;
      gate_q <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_enset)
      begin
        en_q   <= en_q | {reg_wdata[UHCSR_POS_EN_OWN], reg_wdata[UHCSR_EV_LOW_W-1:0]};
        gate_q <= gate_q | reg_wdata[UHCSR_POS_GATE];
      end
      else if (wr_enclr)
      begin
        en_q   <= en_q & ~{reg_wdata[UHCSR_POS_EN_OWN], reg_wdata[UHCSR_EV_LOW_W-1:0]};
        gate_q <= gate_q & ~reg_wdata[UHCSR_POS_GATE];
      end
    end
  end

  AST_DIS_CLEARS: assert property (
    wr_enclr && reg_wdata[UHCSR_POS_GATE] |=> !gate_q ##1 (!$past(ce) || !irq))
    else $error("disable write left the gate open");

  // write-one-to-set: every implemented bit written as one reads back set
  AST_EN_SET: assert property (
    wr_enset |=> (~en_word & $past(reg_wdata) & UHCSR_EN_MAP) == 32'h00000000)
    else $error("enable write of ones left a bit clear");

  ////////////////////////////////////////////////////////////////////////////
  // interrupt request, registered so the pin is glitch free; it follows
  // the flags one cycle later
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      irq_q <= 1'b0;
    end
    else if (ce)
    begin
      irq_q <= gate_q && ((flags_q & en_q) != 8'h00);
    end
  end

  AST_IRQ_RAISE: assert property (
    ce && gate_q && (flags_q[2] && en_q[2]) |=> irq)
    else $error("enabled pending event raised no interrupt");
  AST_IRQ_MASKED: assert property (
    ce && ((flags_q & en_q) == 8'h00) |=> !irq)
    else $error("interrupt without an enabled pending event");

  ////////////////////////////////////////////////////////////////////////////
  // read port: data and valid one cycle after the read strobe;
  // unmapped offsets answer zero
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rdata_q  <= 32'h00000000;
      rvalid_q <= 1'b0;
    end
    else if (ce)
    begin
      rvalid_q <= reg_rd;
      if (reg_rd)
      begin
        unique case (reg_addr)
          UHCSR_OFS_MODE:  rdata_q <= mode_word;
          UHCSR_OFS_CMD:   rdata_q <= cmd_word;
          UHCSR_OFS_FLAGS: rdata_q <= flags_word;
          UHCSR_OFS_ENSET: rdata_q <= en_word;
          UHCSR_OFS_ENCLR: rdata_q <= en_word;
          default:         rdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  AST_READ_CMD: assert property (
    ce && reg_rd && reg_addr == UHCSR_OFS_CMD |=> reg_rvalid && reg_rdata == $past(cmd_word))
    else $error("command read returned stale data");
  AST_FREEZE: assert property (
    !ce |=> $stable(mode_q) && $stable(cmd_q) && $stable(flags_q) && $stable(irq))
    else $error("state moved while clock enable low");

  COV_CMD_ACCUM: cover property (wr_cmd ##2 wr_cmd ##1 cmd_q[1] && cmd_q[2]);
  COV_IRQ: cover property (ce && hc_event[4] ##[1:4] irq);
  COV_SET_VS_CLR: cover property (wr_flags && wev[0] && hc_event[0]);
  COV_STATE_RUN: cover property (mode_q.functional_state == UHCSR_STATE_RUNNING);
  COV_FREEZE: cover property (!ce ##1 ce && mode_q.functional_state == UHCSR_STATE_SUSPENDED);

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from registers
  assign mode          = mode_q;
  assign cmd           = cmd_q;
  assign overrun_count = soc_q;
  assign irq           = irq_q;
  assign reg_rdata     = rdata_q;
  assign reg_rvalid    = rvalid_q;

endmodule

// *** verif/uhcsr_drv_model.sv ***
// driver-side model of the register strobe bus
`timescale 1ns/100ps

module uhcsr_drv_model
(
  input  wire logic        mclk,
  output logic      [7:0]  reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [31:0] reg_wdata
);
  // idle bus: strobes low
  initial
  begin
    reg_addr  = 8'hff;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 32'h0;
  end

  ////////////////////////////////////////
  // one access per call, taken at the rising edge between two falling edges;
  // address and data are inverted afterwards so a stale value never looks valid
  task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(negedge mclk);
    reg_addr  = a;
    reg_wr    = w;
    reg_rd    = !w; // a read on every call that is not a write
    reg_wdata = d;
    @(negedge mclk);
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask
endmodule

// *** verif/tb_top.sv ***
// self-checking bench of the control/status register bank
`timescale 1ns/100ps

module tb_top
  import uhcsr_pkg::*;
;
  logic             mclk;
  logic             rst;
  logic             ce;
  logic      [7:0]  reg_addr;
  logic             reg_wr;
  logic             reg_rd;
  logic      [31:0] reg_wdata;
  logic      [31:0] reg_rdata;
  logic             reg_rvalid;
  uhcsr_hc_upd_s    hc_upd;
  logic      [7:0]  hc_event;
  uhcsr_mode_s      mode;
  logic      [3:0]  cmd;
  logic      [1:0]  overrun_count;
  logic             irq;
  int               error_cnt;
  int               samples_checked;
  logic      [31:0] exp_q[$];
  logic      [31:0] seed;
  logic      [31:0] r;
  logic      [31:0] fb;
  logic      [31:0] eb;

  // 100 MHz clock
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  uhcsr_regs uhcsr_regs_i (.mclk(mclk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .hc_upd(hc_upd), .hc_event(hc_event), .mode(mode),
    .cmd(cmd), .overrun_count(overrun_count), .irq(irq));
  uhcsr_drv_model uhcsr_drv_model_i (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata));

  ////////////////////////////////////////
  function automatic logic [31:0] xrand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(string n, logic [31:0] e, logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      error_cnt++;
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    uhcsr_drv_model_i.access(1'b1, a, d);
  endtask

  // expectation is queued before the strobe so the monitor always finds it
  task automatic rd(logic [7:0] a, logic [31:0] e);
    exp_q.push_back(e);
    uhcsr_drv_model_i.access(1'b0, a, 32'h0);
  endtask

  task automatic pulse(logic [7:0] ev);
    @(negedge mclk);
    hc_event = ev;
    @(negedge mclk);
    hc_event = 8'h00;
  endtask

  task automatic eng(uhcsr_hc_upd_s u);
    @(negedge mclk);
    hc_upd = u;
    @(negedge mclk);
    hc_upd = '0;
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////
  // read monitor: oldest note against each returned word
  always @(negedge mclk)
  begin
    if (reg_rvalid === 1'b1)
    begin
      if (exp_q.size() > 0)
        check("read data", exp_q.pop_front(), reg_rdata);
      else
        check("unrequested read", 32'h0, 32'h1);
    end
  end

  // hang guard
  initial
  begin
    #1000000;
    check("timeout", 32'h0, 32'h1);
    give_verdict();
  end

  ////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    hc_upd = '0;
    hc_event = 8'h00;
    seed = 32'd24;
    error_cnt = 0;
    samples_checked = 0;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    // reset values and two unmapped offsets
    rd(UHCSR_OFS_MODE, 32'h1);
    rd(UHCSR_OFS_CMD, 32'h0);
    rd(UHCSR_OFS_FLAGS, 32'h0);
    rd(UHCSR_OFS_ENSET, 32'h0);
    rd(8'h00, 32'h0);
    rd(8'h18, 32'h0);
    // random mode words, reserved bits dropped
    for (int i = 0; i < 6; i++)
    begin
      r = xrand();
      wr(UHCSR_OFS_MODE, r);
      rd(UHCSR_OFS_MODE, r & 32'h7ff);
      check("mode port", 32'(r[10:0]), 32'(mode));
    end
    // engine walks every state code; only state, wakeup-attached and the overrun count move
    wr(UHCSR_OFS_MODE, 32'h53d);
    for (int s = 0; s < 4; s++)
    begin
      eng(uhcsr_hc_upd_s'({1'b1, 2'(s), 1'b1, s[0], 4'h0, 1'b1, 2'(s)}));
      rd(UHCSR_OFS_MODE, 32'h53d | (s << 6) | (s[0] << 9));
      rd(UHCSR_OFS_CMD, s << 16);
      check("overrun port", 32'(s), 32'(overrun_count));
    end
    // write-to-set commands accumulate, count field ignores writes
    wr(UHCSR_OFS_CMD, 32'h2);
    wr(UHCSR_OFS_CMD, 32'h4);
    wr(UHCSR_OFS_CMD, 32'h0);
    rd(UHCSR_OFS_CMD, 32'h3_0006);
    check("cmd port", 32'h6, 32'(cmd));
    eng(uhcsr_hc_upd_s'({5'h0, 4'h2, 3'h0}));
    rd(UHCSR_OFS_CMD, 32'h3_0004);
    wr(UHCSR_OFS_CMD, 32'hf);
    rd(UHCSR_OFS_CMD, 32'h3_000f);
    // every event: masked, enabled, gated off, cleared
    for (int i = 0; i < 8; i++)
    begin
      fb = (i < 7) ? (32'h1 << i) : 32'h8000_0000;
      eb = (i < 7) ? fb : 32'h4000_0000;
      pulse(8'(1 << i));
      rd(UHCSR_OFS_FLAGS, fb);
      check("irq masked", 32'h0, 32'(irq));
      wr(UHCSR_OFS_ENSET, eb | 32'h8000_0000);
      rd(UHCSR_OFS_ENCLR, eb | 32'h8000_0000);
      check("irq raised", 32'h1, 32'(irq));
      wr(UHCSR_OFS_ENCLR, 32'h8000_0000);
      rd(UHCSR_OFS_ENSET, eb);
      check("irq gated", 32'h0, 32'(irq));
      wr(UHCSR_OFS_ENSET, 32'h8000_0000);
      wr(UHCSR_OFS_FLAGS, fb);
      rd(UHCSR_OFS_FLAGS, 32'h0);
      check("irq cleared", 32'h0, 32'(irq));
      wr(UHCSR_OFS_ENCLR, eb);
    end
    // clock enable low: a mode write and an event are both lost
    @(negedge mclk);
    ce = 1'b0;
    wr(UHCSR_OFS_MODE, 32'h0);
    pulse(8'h01);
    @(negedge mclk);
    ce = 1'b1;
    rd(UHCSR_OFS_MODE, 32'h7fd);
    rd(UHCSR_OFS_FLAGS, 32'h0);
    // let the last answers land
    for (int k = 0; k < 10 && exp_q.size() > 0; k++)
      @(negedge mclk);
    check("pending reads", 32'h0, 32'(exp_q.size()));
    give_verdict();
  end
endmodule
